// ==== rtl/ccd_timing_gen.sv ====
`timescale 1ns/1ps
module ccd_timing_gen
  import ccd_readout_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Configuration
  input wire logic dualMode,
  input wire logic [HOLD_W-1:0] holdCycles,
  input wire logic dumpRow,
  input wire logic startFrame,
  // Link to the sensor
  ccd_link_if.timing link,
  // Pixel stream
  output logic pixValid,
  output logic darkValid,
  output logic [PIX_W-1:0] pixLeft,
  output logic [PIX_W-1:0] pixRight,
  output logic lineDone,
  output logic frameDone,
  output logic busy
);

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_VSHIFT = 2'b01,
    ST_HOLD = 2'b10,
    ST_HCLK = 2'b11
  } state_t;

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  state_t st_ff, nxt_st;
  logic [HOLD_W-1:0] cnt_ff, nxt_cnt; // Shared delay counter
  logic [COL_W-1:0] col_ff, nxt_col; // Horizontal clocks sent
  logic [ROW_W-1:0] row_ff, nxt_row; // Rows transferred
  logic ph_ff, nxt_ph; // Horizontal half period
  logic dump_ff, nxt_dump; // Dump level latched at frame start and at line end
  logic [COL_W-1:0] lastCol;

  // Mode chosen once per frame so a line never changes mode
  logic dual_ff, nxt_dual;
  assign lastCol = dual_ff ? COL_W'(DUAL_LINE_CLOCKS - 1) :
                   COL_W'(SINGLE_LINE_CLOCKS - 1);

  always_comb
  begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_col = col_ff;
    nxt_row = row_ff;
    nxt_ph = ph_ff;
    nxt_dump = dump_ff;
    nxt_dual = dual_ff;
    case (st_ff)
      ST_IDLE:
      begin
        if (startFrame)
        begin
          nxt_dual = dualMode;
          nxt_row = '0;
          nxt_cnt = '0;
          nxt_dump = dumpRow;
          nxt_st = ST_VSHIFT;
        end
      end
      ST_VSHIFT:
      begin
        // Vertical pulse of fixed width
        nxt_cnt = cnt_ff + 1'b1;
        if (cnt_ff == HOLD_W'(VPULSE_CYC - 1))
        begin
          nxt_cnt = '0;
          nxt_st = ST_HOLD;
        end
      end
      ST_HOLD:
      begin
        // Wait after vertical falling edge
        nxt_cnt = cnt_ff + 1'b1;
        if (cnt_ff >= holdCycles)
        begin
          nxt_cnt = '0;
          nxt_col = '0;
          nxt_ph = 1'b0;
          nxt_st = ST_HCLK;
        end
      end
      ST_HCLK:
      begin
        nxt_ph = !ph_ff;
        if (ph_ff)
        begin
          nxt_col = col_ff + 1'b1;
          if (col_ff == lastCol)
          begin
            nxt_row = row_ff + 1'b1;
            nxt_dump = dumpRow;
            // Vertical only moves between lines
            nxt_st = (row_ff == ROW_W'(FRAME_ROWS - 1)) ? ST_IDLE :
                     ST_VSHIFT;
          end
        end
      end
      default: nxt_st = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_ff <= ST_IDLE;
      cnt_ff <= '0;
      col_ff <= '0;
      row_ff <= '0;
      ph_ff <= 1'b0;
      dump_ff <= 1'b0;
      dual_ff <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      col_ff <= nxt_col;
      row_ff <= nxt_row;
      ph_ff <= nxt_ph;
      dump_ff <= nxt_dump;
      dual_ff <= nxt_dual;
    end
  end

  // ----------------------------------------------------------------
  // Phase outputs
  // ----------------------------------------------------------------
  // Horizontal parked A high, B low outside clocking
  assign link.horizPhaseA = (st_ff == ST_HCLK) ? ph_ff : 1'b1;
  assign link.horizPhaseB = (st_ff == ST_HCLK) ? !ph_ff : 1'b0;
  assign link.vertPhaseA = (st_ff == ST_VSHIFT);
  assign link.vertPhaseB = (st_ff == ST_VSHIFT);
  assign link.horizRightRev = dual_ff;
  // Dump held only across the transfer
  assign link.lineDumpCtrl = (st_ff == ST_VSHIFT) && dump_ff;

  // ----------------------------------------------------------------
  // Pixel qualifiers
  // ----------------------------------------------------------------
  // Sensor answers after two sync stages plus its register
  logic [COL_W-1:0] sampCol_ff;
  logic [ROW_W-1:0] sampRow_ff;
  logic sampEn_ff, valid_ff, dark_ff, lineDone_ff, frameDone_ff;
  logic [PIX_W-1:0] pl_ff, pr_ff;
  logic [COL_W-1:0] actStart, actEnd;
  logic rowOk;
  assign actStart = COL_W'(EMPTY_PIX + DARK_PIX + BUFFER_PIX);
  assign actEnd = dual_ff ? COL_W'(EMPTY_PIX + DARK_PIX + ACTIVE_PIX_DUAL) :
                  COL_W'(EMPTY_PIX + DARK_PIX + ACTIVE_PIX_SINGLE
                         - BUFFER_PIX);
  assign rowOk = sampRow_ff >= ROW_W'(TOP_DARK_ROWS + BUFFER_ROWS) &&
                 sampRow_ff < ROW_W'(TOP_DARK_ROWS + ACTIVE_ROWS
                                     - BUFFER_ROWS);

  // Sample video late in the high phase, a full half period after edge
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sampCol_ff <= '0;
      sampRow_ff <= '0;
      sampEn_ff <= 1'b0;
      valid_ff <= 1'b0;
      dark_ff <= 1'b0;
      pl_ff <= '0;
      pr_ff <= '0;
      lineDone_ff <= 1'b0;
      frameDone_ff <= 1'b0;
    end
    else
    begin
      sampEn_ff <= (st_ff == ST_HCLK) && ph_ff;
      sampCol_ff <= col_ff;
      // Line index counts from the first transferred row
      sampRow_ff <= row_ff;
      // Right output pixels stored reversed downstream
      valid_ff <= sampEn_ff && rowOk && !dump_ff && sampCol_ff >= actStart &&
                  sampCol_ff < actEnd;
      // Leading block always, trailing block only in single mode
      dark_ff <= sampEn_ff && ((sampCol_ff >=
                 COL_W'(EMPTY_PIX + DARK_EDGE_SKIP)
                 && sampCol_ff < COL_W'(EMPTY_PIX + DARK_PIX
                                        - DARK_EDGE_SKIP)) ||
                 (!dual_ff && sampCol_ff >= COL_W'(EMPTY_PIX + DARK_PIX
                  + ACTIVE_PIX_SINGLE + DARK_EDGE_SKIP) &&
                  sampCol_ff < COL_W'(EMPTY_PIX + 2 * DARK_PIX
                  + ACTIVE_PIX_SINGLE - DARK_EDGE_SKIP)));
      pl_ff <= link.videoLeft;
      pr_ff <= link.videoRight;
      lineDone_ff <= (st_ff == ST_HCLK) && ph_ff && col_ff == lastCol;
      frameDone_ff <= (st_ff == ST_HCLK) && ph_ff && col_ff == lastCol &&
                      row_ff == ROW_W'(FRAME_ROWS - 1);
    end
  end

  assign pixValid = valid_ff;
  assign darkValid = dark_ff;
  assign pixLeft = pl_ff;
  assign pixRight = pr_ff;
  assign lineDone = lineDone_ff;
  assign frameDone = frameDone_ff;
  assign busy = (st_ff != ST_IDLE);

endmodule

// ==== include/ccd_readout_pkg.sv ====
package ccd_readout_pkg;

  // ----------------------------------------------------------------
  // Frame structure
  // ----------------------------------------------------------------
  localparam int TOP_DARK_ROWS = 2;
  localparam int ACTIVE_ROWS = 1208;
  localparam int BOTTOM_DARK_ROWS = 4;
  localparam int BUFFER_ROWS = 4;
  localparam int FRAME_ROWS = TOP_DARK_ROWS + ACTIVE_ROWS + BOTTOM_DARK_ROWS;

  // ----------------------------------------------------------------
  // Line structure
  // ----------------------------------------------------------------
  localparam int EMPTY_PIX = 4;
  localparam int DARK_PIX = 16;
  localparam int ACTIVE_PIX_SINGLE = 1608;
  localparam int ACTIVE_PIX_DUAL = 800;
  localparam int BUFFER_PIX = 4;
  localparam int HALF_REG_PIX = 824;
  localparam int SINGLE_LINE_CLOCKS = 1644;
  localparam int DUAL_LINE_CLOCKS = 824;
  localparam int DARK_EDGE_SKIP = 1;

  // ----------------------------------------------------------------
  // Widths and timing
  // ----------------------------------------------------------------
  localparam int PIX_W = 12;
  localparam int ROW_W = 11;
  localparam int COL_W = 11;
  localparam int CLK_MHZ = 40;
  localparam int VPULSE_NS = 1000;
  localparam int VPULSE_CYC = (VPULSE_NS * CLK_MHZ) / 1000;
  localparam int HOLD_W = 16;
  localparam logic [HOLD_W-1:0] HOLD_RESET = 16'h0028;

  // Pixel class reported by the sensor model
  typedef enum logic [1:0]
  {
    PIX_EMPTY = 2'b00,
    PIX_DARK = 2'b01,
    PIX_ACTIVE = 2'b10
  } pix_class_t;

  // Pixel value at a row and column: a plain deterministic pattern
  function automatic logic [PIX_W-1:0] pix_value
  (
    input logic [ROW_W-1:0] row,
    input logic [COL_W-1:0] col
  );
    pix_value = PIX_W'({row[5:0], col[5:0]});
  endfunction

endpackage

// ==== include/ccd_link_if.sv ====
`timescale 1ns/1ps
// Phase clocks from the timing generator and video back from the sensor
interface ccd_link_if;
  logic vertPhaseA;
  logic vertPhaseB;
  logic horizPhaseA;
  logic horizPhaseB;
  logic horizRightRev;
  logic lineDumpCtrl;
  logic [11:0] videoLeft;
  logic [11:0] videoRight;

  modport sensor
  (
    input vertPhaseA, vertPhaseB, horizPhaseA, horizPhaseB,
    input horizRightRev, lineDumpCtrl,
    output videoLeft, videoRight
  );
  modport timing
  (
    output vertPhaseA, vertPhaseB, horizPhaseA, horizPhaseB,
    output horizRightRev, lineDumpCtrl,
    input videoLeft, videoRight
  );
endinterface

// ==== rtl/ccd_sensor_model.sv ====
`timescale 1ns/1ps
// Function
// - Frame: 2 dark, 1208 active, 4 dark
// - Drop 4 top and bottom buffer rows
// - Single mode: everything exits left output
// - Single line: 4 empty,16 dark,1608,16 dark
// - Drop 4 buffer pixels each end
// - Dual mode: right half clocked reversed
// - Dual output: 4 empty,16 dark,800 active
// - Rebuild: reverse right half, append
// - Vertical pulse moves rows toward register
// - Vertical shift: phases A and B both high
// - Wait hold delay before horizontal restart
// - Dump high during transfer discards row
// - Clock 1644 single, 824 dual
// - No vertical or dump pulses mid line
// - Use only centre 14 dark columns
module ccd_sensor_model
  import ccd_readout_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Link to the timing generator
  ccd_link_if.sensor link,
  // Observation
  output logic [ROW_W-1:0] rowIndex,
  output logic rowDumped,
  output pix_class_t leftClass
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [5:0] syncA_ff; // First stage
  logic [5:0] syncB_ff; // Second stage, used by logic
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      // Idle pin levels: horizontal A parked high, so no false edge
      syncA_ff <= 6'h08;
      syncB_ff <= 6'h08;
    end
    else
    begin
      syncA_ff <= {link.vertPhaseA, link.vertPhaseB, link.horizPhaseA,
                   link.horizPhaseB, link.horizRightRev, link.lineDumpCtrl};
      syncB_ff <= syncA_ff;
    end
  end
  logic vA, hA, rev, dump;
  assign vA = syncB_ff[5];
  assign hA = syncB_ff[3];
  assign rev = syncB_ff[1];
  assign dump = syncB_ff[0];

  // ----------------------------------------------------------------
  // Row and column state
  // ----------------------------------------------------------------
  logic [ROW_W-1:0] row_ff, nxt_row; // Row now in the horizontal register
  logic [COL_W-1:0] col_ff, nxt_col; // Pixels already shifted out
  logic vPrev_ff, nxt_vPrev; // Edge detect on vertical phase
  logic hPrev_ff, nxt_hPrev; // Edge detect on horizontal phase
  logic dumped_ff, nxt_dumped; // Current row was discarded
  logic dPrev_ff, nxt_dPrev; // Dump level seen while vertical high
  logic [PIX_W-1:0] vl_ff, nxt_vl, vr_ff, nxt_vr;
  pix_class_t cls_ff, nxt_cls;

  // Classify a position along one output's stream
  function automatic pix_class_t classify(input logic [COL_W-1:0] c,
                                          input logic dual);
    if (c < COL_W'(EMPTY_PIX))
      classify = PIX_EMPTY;
    else if (c < COL_W'(EMPTY_PIX + DARK_PIX))
      classify = PIX_DARK;
    else if (dual || c < COL_W'(EMPTY_PIX + DARK_PIX + ACTIVE_PIX_SINGLE))
      classify = PIX_ACTIVE;
    else
      classify = PIX_DARK;
  endfunction

  // Next-state logic
  always_comb
  begin
    nxt_row = row_ff;
    nxt_col = col_ff;
    nxt_vPrev = vA;
    nxt_hPrev = hA;
    nxt_dumped = dumped_ff;
    nxt_dPrev = dump;
    nxt_vl = vl_ff;
    nxt_vr = vr_ff;
    nxt_cls = cls_ff;
    // Falling edge of vertical pulse advances one row
    if (vPrev_ff && !vA)
    begin
      nxt_row = (row_ff == ROW_W'(FRAME_ROWS - 1)) ? '0 : row_ff + 1'b1;
      nxt_col = '0;
      // Dump drops with the pulse, so use the level one cycle earlier
      nxt_dumped = dPrev_ff;
    end
    // Horizontal rising edge shifts one pixel out
    else if (!hPrev_ff && hA)
    begin
      nxt_cls = classify(col_ff, rev);
      // Single mode: all pixels on left output
      nxt_vl = (dumped_ff || classify(col_ff, rev) == PIX_EMPTY) ? '0 :
               pix_value(row_ff, col_ff);
      // Dual mode right output carries mirrored columns
      nxt_vr = (!rev || dumped_ff) ? '0 :
               pix_value(row_ff, COL_W'(2 * HALF_REG_PIX - 1) - col_ff);
      nxt_col = col_ff + 1'b1;
    end
  end

  // Registers
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      row_ff <= '0;
      col_ff <= '0;
      vPrev_ff <= 1'b0;
      hPrev_ff <= 1'b1;
      dumped_ff <= 1'b0;
      dPrev_ff <= 1'b0;
      vl_ff <= '0;
      vr_ff <= '0;
      cls_ff <= PIX_EMPTY;
    end
    else
    begin
      row_ff <= nxt_row;
      col_ff <= nxt_col;
      vPrev_ff <= nxt_vPrev;
      hPrev_ff <= nxt_hPrev;
      dumped_ff <= nxt_dumped;
      dPrev_ff <= nxt_dPrev;
      vl_ff <= nxt_vl;
      vr_ff <= nxt_vr;
      cls_ff <= nxt_cls;
    end
  end

  assign link.videoLeft = vl_ff;
  assign link.videoRight = vr_ff;
  assign rowIndex = row_ff;
  assign rowDumped = dumped_ff;
  assign leftClass = cls_ff;

endmodule

// ==== tb/ccd_link_props.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Link checker
// ----------------------------------------------------------------
module ccd_link_props
  import ccd_readout_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Phase clocks
  input wire logic vertPhaseA,
  input wire logic vertPhaseB,
  input wire logic horizPhaseA,
  input wire logic horizPhaseB,
  input wire logic horizRightRev,
  input wire logic lineDumpCtrl,
  // Video
  input wire logic [11:0] videoLeft,
  input wire logic [11:0] videoRight
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  // Cycles the vertical pulse has been high
  logic [7:0] vertCnt_ff;
  logic [7:0] nxt_vertCnt;

  // Count while high, clear when low
  always_comb
  begin
    nxt_vertCnt = vertPhaseA ? vertCnt_ff + 8'h01 : 8'h00;
  end

  // Counter register
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      vertCnt_ff <= 8'h00;
    else
      vertCnt_ff <= nxt_vertCnt;
  end

  property p_park;
    vertPhaseA |-> horizPhaseA && !horizPhaseB;
  endproperty
  property p_hcomp;
    horizPhaseA != horizPhaseB;
  endproperty
  property p_vpair;
    vertPhaseA == vertPhaseB;
  endproperty
  property p_vwidth;
    $fell(vertPhaseA) |-> vertCnt_ff == VPULSE_CYC;
  endproperty
  // Shortest hold the bench uses is two, plus one wait cycle
  property p_hold;
    $fell(vertPhaseA) |-> (horizPhaseA && !horizPhaseB) [*3];
  endproperty
  property p_hlow;
    $fell(horizPhaseA) |=> horizPhaseA;
  endproperty
  property p_quiet;
    $changed(horizPhaseA) |-> !vertPhaseA && !lineDumpCtrl;
  endproperty
  property p_revhold;
    $changed(horizPhaseA) |-> $stable(horizRightRev);
  endproperty

  a_park: assert property (p_park)
    else $error("horizontal phases not parked in vertical shift");
  a_hcomp: assert property (p_hcomp)
    else $error("horizontal phases not complementary");
  a_vpair: assert property (p_vpair)
    else $error("vertical phases differ");
  a_vwidth: assert property (p_vwidth)
    else $error("vertical pulse width wrong");
  a_hold: assert property (p_hold)
    else $error("horizontal restart too early");
  a_hlow: assert property (p_hlow)
    else $error("horizontal low phase too long");
  a_quiet: assert property (p_quiet)
    else $error("vertical or dump active while shifting");
  a_revhold: assert property (p_revhold)
    else $error("reverse select moved mid line");

  // Main scenarios
  c_vfall: cover property ($fell(vertPhaseA));
  c_dual: cover property (horizRightRev && $fell(horizPhaseA));
  c_dump: cover property (lineDumpCtrl && vertPhaseA);
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench
  import ccd_readout_pkg::*;
;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic dualMode = 1'b0;
  logic dumpRow = 1'b0;
  logic startFrame = 1'b0;
  logic [HOLD_W-1:0] holdCycles = HOLD_RESET;
  logic pixValid, darkValid, lineDone, busy, rowDumped;
  int n_fail = 0;
  int samples_checked = 0;
  int hClk, pixCnt, darkCnt, gap, gapSeen;
  logic prevA = 1'b1;
  logic prevV = 1'b0;
  bit inGap = 0;

  // 40 MHz clock
  always #12.5 ref_clk = ~ref_clk;

  ccd_link_if ccd_link_if_i ();
  ccd_sensor_model ccd_sensor_model_i (.ref_clk(ref_clk), .arst_n(arst_n),
    .link(ccd_link_if_i.sensor), .rowIndex(), .rowDumped(rowDumped),
    .leftClass());
  ccd_timing_gen ccd_timing_gen_i (.ref_clk(ref_clk), .arst_n(arst_n),
    .dualMode(dualMode), .holdCycles(holdCycles), .dumpRow(dumpRow),
    .startFrame(startFrame), .link(ccd_link_if_i.timing),
    .pixValid(pixValid), .darkValid(darkValid), .pixLeft(), .pixRight(),
    .lineDone(lineDone), .frameDone(), .busy(busy));
  ccd_link_props ccd_link_props_i (.ref_clk(ref_clk), .arst_n(arst_n),
    .vertPhaseA(ccd_link_if_i.vertPhaseA),
    .vertPhaseB(ccd_link_if_i.vertPhaseB),
    .horizPhaseA(ccd_link_if_i.horizPhaseA),
    .horizPhaseB(ccd_link_if_i.horizPhaseB),
    .horizRightRev(ccd_link_if_i.horizRightRev),
    .lineDumpCtrl(ccd_link_if_i.lineDumpCtrl),
    .videoLeft(ccd_link_if_i.videoLeft),
    .videoRight(ccd_link_if_i.videoRight));

  // ----------------------------------------------------------------
  // Line monitor: horizontal clocks, qualifiers, restart gap
  // ----------------------------------------------------------------
  always @(posedge ref_clk)
  begin
    if (prevA && !ccd_link_if_i.horizPhaseA && inGap)
    begin
      inGap = 0;
      gapSeen = gap;
    end
    if (prevA && !ccd_link_if_i.horizPhaseA)
      hClk++;
    if (inGap)
      gap++;
    // Gap starts at the end of the vertical pulse
    if (prevV && !ccd_link_if_i.vertPhaseA)
    begin
      inGap = 1;
      gap = 0;
    end
    pixCnt += (pixValid === 1'b1);
    darkCnt += (darkValid === 1'b1);
    prevA = ccd_link_if_i.horizPhaseA;
    prevV = ccd_link_if_i.vertPhaseA;
  end

  // ----------------------------------------------------------------
  // Expectations and compares
  // ----------------------------------------------------------------
  // Clocks per line
  function automatic int exp_hclk(input logic dual);
    return dual ? DUAL_LINE_CLOCKS : SINGLE_LINE_CLOCKS;
  endfunction
  // Valid pixels: none in top dark or top buffer rows, buffers trimmed
  function automatic int exp_pix(input logic dual, input int row);
    if (row < TOP_DARK_ROWS + BUFFER_ROWS)
      return 0;
    return dual ? ACTIVE_PIX_DUAL - BUFFER_PIX
                : ACTIVE_PIX_SINGLE - 2 * BUFFER_PIX;
  endfunction
  // Centre dark columns only, one block per edge seen
  function automatic int exp_dark(input logic dual);
    return dual ? DARK_PIX - 2 : 2 * (DARK_PIX - 2);
  endfunction

  task automatic chk_cnt(input string what, input int exp, input int got);
    samples_checked++;
    if (exp != got)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic chk_bit(input string what, input logic exp, input logic got);
    samples_checked++;
    if (exp !== got)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic summarize();
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // One partial frame; reset first, so a second call aborts mid frame
  // ----------------------------------------------------------------
  task automatic run_mode(input logic dual);
    int r;
    int t;
    @(posedge ref_clk);
    arst_n <= 1'b0;
    dualMode <= dual;
    dumpRow <= 1'b0;
    holdCycles <= HOLD_W'(2 + $urandom % 7);
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    startFrame <= 1'b1;
    @(posedge ref_clk);
    startFrame <= 1'b0;
    @(negedge ref_clk);
    hClk = 0;
    pixCnt = 0;
    darkCnt = 0;
    // Full frame is too long; first valid row is enough
    for (r = 0; r < 7; r++)
    begin
      t = 0;
      while (lineDone !== 1'b1 && t < 4000)
      begin
        @(negedge ref_clk);
        t++;
      end
      if (t >= 4000)
      begin
        n_fail++;
        summarize();
      end
      @(negedge ref_clk);
      chk_bit("busy", 1'b1, busy);
      chk_cnt("pixels", exp_pix(dual, r), pixCnt);
      chk_bit("hold", 1'b1, gapSeen >= int'(holdCycles));
      if (!(dual && r == 2))
      begin
        chk_cnt("hclocks", exp_hclk(dual), hClk);
        chk_cnt("dark", exp_dark(dual), darkCnt);
      end
      if (r == 2 || r == 3)
        chk_bit("dumped", dual && r == 2, rowDumped);
      hClk = 0;
      pixCnt = 0;
      darkCnt = 0;
      // Dump one buffer row in dual mode; restart must be refused
      @(posedge ref_clk);
      // Latched at the end of the next line, so row 2 is dumped
      dumpRow <= dual && r == 0;
      startFrame <= (r == 3);
      @(posedge ref_clk);
      startFrame <= 1'b0;
    end
  endtask

  // Watchdog over both partial frames
  initial
  begin
    repeat (60000) @(posedge ref_clk);
    n_fail++;
    summarize();
  end

  // Main sequence
  initial
  begin
    void'($urandom(32'h1c92a619));
    run_mode(1'b0);
    run_mode(1'b1);
    summarize();
  end
endmodule
